/* hw/feq_cfg.svh */
// feq_cfg.svh: offsets, field positions, reset values and counts for the equalizer coefficient bank
// assumes: included by bare name; definitions only
`ifndef FEQ_CFG_SVH
`define FEQ_CFG_SVH

// register indices; byte address is four times the index
`define FEQ_IDX_A_TAP6      12'h423
`define FEQ_IDX_A_TAP7      12'h425
`define FEQ_IDX_A_TAP8      12'h427
`define FEQ_IDX_A_TAP9      12'h429
`define FEQ_IDX_B_TAP1      12'h448
`define FEQ_IDX_B_TAP2      12'h44A
`define FEQ_IDX_B_TAP3      12'h44C

// field layout of a non-center tap register
`define FEQ_REG_W           16
`define FEQ_COEF_LSB        0
`define FEQ_COEF_MSB        11
`define FEQ_RSVD_LSB        12
`define FEQ_RSVD_MSB        15
`define FEQ_REG_RESET       16'h0000

// filter structure
`define FEQ_NUM_TAPS        9
`define FEQ_CENTER_W        18
`define FEQ_NUM_REGS        7

// axi responses
`define FEQ_RESP_OKAY       2'h0
`define FEQ_RESP_SLVERR     2'h2

`endif

/* hw/feq_pkg.sv */
// feq_pkg.sv: types shared by the equalizer coefficient bank
// assumes: nothing beyond standard SystemVerilog
package feq_pkg;

	// result of matching a bus address against the index table
	typedef enum logic [1:0] {
		FEQ_SEL_NONE,
		FEQ_SEL_HIT,
		FEQ_SEL_MISS
	} feq_sel_t;

	// write-channel handshake state
	typedef enum logic [1:0] {
		FEQ_WR_IDLE,
		FEQ_WR_RESP
	} feq_wr_state_t;

	// read-channel handshake state
	typedef enum logic [1:0] {
		FEQ_RD_IDLE,
		FEQ_RD_RESP
	} feq_rd_state_t;

endpackage : feq_pkg

/* hw/feq_reg_if.sv */
// feq_reg_if.sv: write and read strobes between the bus slave and the coefficient bank
// assumes: all members on the bus clock
`timescale 1ns/1ps
interface feq_reg_if #(
	parameter int NREG = 7
);
	logic [NREG-1:0] wr_en;    // one-hot write strobe
	logic [15:0]     wr_data;  // low half of bus word
	logic [1:0]      wr_strb;  // byte lanes 0 and 1
	logic [NREG-1:0] rd_sel;   // one-hot read select
	logic [15:0]     rd_data;  // selected register, combinational

	modport bank  (input wr_en, input wr_data, input wr_strb, input rd_sel, output rd_data);
	modport slave (output wr_en, output wr_data, output wr_strb, output rd_sel, input rd_data);
endinterface : feq_reg_if

/* hw/feq_coef_reg.sv */
// feq_coef_reg.sv: one 16-bit coefficient register, 12-bit tap plus 4 reserved rw bits
// assumes: write strobe and data come from same-clock logic
`timescale 1ns/1ps
`include "feq_cfg.svh"
module feq_coef_reg
	import feq_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_strb,
	output logic      [15:0] value
);
	logic [15:0] next_value;

	// byte lanes merge; reserved nibble is stored like the tap
	always_comb begin
		next_value = value;
		if (ce && wr_en) begin
			if (wr_strb[0]) next_value[7:0]  = wr_data[7:0];
			if (wr_strb[1]) next_value[15:8] = wr_data[15:8];
		end
	end

	// zero after reset, reserved bits too
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) value <= `FEQ_REG_RESET;
		else        value <= next_value;
	end

	// a tap may only move on its own write strobe
	property p_hold_no_write;
		@(posedge clk) disable iff (!rst_n)
		!(ce && wr_en) |=> value == $past(value);
	endproperty
	a_hold_no_write: assert property (p_hold_no_write)
		else $error("coef changed without write");
endmodule : feq_coef_reg

/* hw/feq_coef_bank.sv */
// feq_coef_bank.sv: equalizer coefficient bank with AXI4-Lite register access
// assumes: single clock; AXI master follows the standard handshake; filter datapath outside
`timescale 1ns/1ps
`include "feq_cfg.svh"

// What this block does
// - each tap is 12-bit signed in bits 11:0; bits 15:12 reserved read/write
// - channel A tap six register drives sixth tap in both modes
// - register at 0x425 drives seventh channel A or single-filter tap
// - register at 0x427 drives eighth channel A or single-filter tap
// - register at 0x429 drives ninth channel A or single-filter tap
// - register at 0x448 drives first channel B tap in dual mode
// - register at 0x44A drives second channel B tap in dual mode
// - register at 0x44C drives third channel B tap in dual mode
// - every register, reserved bits included, resets to zero
// - filter is nine taps, center tap 18 bits, others 12 bits
module feq_coef_bank
	import feq_pkg::*;
#(
	parameter int ADDR_W = 14,
	parameter int NUM_TAPS = `FEQ_NUM_TAPS,
	parameter int CENTER_W = `FEQ_CENTER_W
)(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// tap weights to the filter datapath
	input  wire logic              dual_mode,
	output logic signed [11:0]     chan_a_tap6_weight,
	output logic signed [11:0]     chan_a_tap7_weight,
	output logic signed [11:0]     chan_a_tap8_weight,
	output logic signed [11:0]     chan_a_tap9_weight,
	output logic signed [11:0]     chan_b_tap1_weight,
	output logic signed [11:0]     chan_b_tap2_weight,
	output logic signed [11:0]     chan_b_tap3_weight
);
	localparam int NREG = `FEQ_NUM_REGS;

	// the bank serves only the nine-tap shape with an 18-bit center
	if (NUM_TAPS != `FEQ_NUM_TAPS || CENTER_W != `FEQ_CENTER_W) begin : g_bad_shape
		$error("feq_coef_bank supports only the nine-tap, 18-bit-center filter");
	end
	if (ADDR_W < 14) begin : g_bad_addr
		$error("feq_coef_bank needs at least 14 address bits");
	end

	// index table, ordered as the register array
	localparam logic [11:0] IDX [NREG] = '{
		`FEQ_IDX_A_TAP6, `FEQ_IDX_A_TAP7, `FEQ_IDX_A_TAP8, `FEQ_IDX_A_TAP9,
		`FEQ_IDX_B_TAP1, `FEQ_IDX_B_TAP2, `FEQ_IDX_B_TAP3
	};

	feq_reg_if #(.NREG(NREG)) rif ();

	logic [15:0] regs [NREG];

	// one register per tap; the same module for all keeps the reset uniform
	for (genvar g = 0; g < NREG; g++) begin : g_reg
		feq_coef_reg u_reg (
			.clk     (clk),
			.rst_n   (rst_n),
			.ce      (ce),
			.wr_en   (rif.wr_en[g]),
			.wr_data (rif.wr_data),
			.wr_strb (rif.wr_strb),
			.value   (regs[g])
		);
	end

	// ---- write channel ----
	feq_wr_state_t              wr_state;
	feq_wr_state_t              next_wr_state;
	logic                       aw_held;
	logic                       next_aw_held;
	logic                       w_held;
	logic                       next_w_held;
	logic [ADDR_W-1:0]          aw_addr;
	logic [ADDR_W-1:0]          next_aw_addr;
	logic [31:0]                w_data;
	logic [31:0]                next_w_data;
	logic [3:0]                 w_strb;
	logic [3:0]                 next_w_strb;
	logic [1:0]                 bresp;
	logic [1:0]                 next_bresp;
	logic [NREG-1:0]            wr_hit;
	logic                       wr_fire;

	// address and data are latched independently, in either order
	assign s_axi_awready = ce && wr_state == FEQ_WR_IDLE && !aw_held;
	assign s_axi_wready  = ce && wr_state == FEQ_WR_IDLE && !w_held;
	assign s_axi_bvalid  = wr_state == FEQ_WR_RESP;
	assign s_axi_bresp   = bresp;

	// decode the latched write address against the index table
	always_comb begin
		wr_hit = '0;
		for (int i = 0; i < NREG; i++) begin
			if (aw_addr[1:0] == 2'h0 && aw_addr[13:2] == IDX[i]) wr_hit[i] = 1'b1;
		end
	end

	assign wr_fire     = ce && wr_state == FEQ_WR_IDLE && aw_held && w_held;
	assign rif.wr_en   = wr_fire ? wr_hit : '0;
	assign rif.wr_data = w_data[15:0];
	assign rif.wr_strb = w_strb[1:0];

	always_comb begin
		next_wr_state = wr_state;
		next_aw_held  = aw_held;
		next_w_held   = w_held;
		next_aw_addr  = aw_addr;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bresp    = bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		case (wr_state)
			FEQ_WR_IDLE: begin
				if (wr_fire) begin
					next_wr_state = FEQ_WR_RESP;
					next_aw_held  = 1'b0;
					next_w_held   = 1'b0;
					next_bresp    = (|wr_hit) ? `FEQ_RESP_OKAY : `FEQ_RESP_SLVERR;
				end
			end
			FEQ_WR_RESP: begin
				if (ce && s_axi_bready) next_wr_state = FEQ_WR_IDLE;
			end
			default: next_wr_state = FEQ_WR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_state <= FEQ_WR_IDLE;
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			aw_addr  <= '0;
			w_data   <= 32'h00000000;
			w_strb   <= 4'h0;
			bresp    <= `FEQ_RESP_OKAY;
		end else begin
			wr_state <= next_wr_state;
			aw_held  <= next_aw_held;
			w_held   <= next_w_held;
			aw_addr  <= next_aw_addr;
			w_data   <= next_w_data;
			w_strb   <= next_w_strb;
			bresp    <= next_bresp;
		end
	end

	// ---- read channel ----
	feq_rd_state_t rd_state;
	feq_rd_state_t next_rd_state;
	logic [31:0]   rdata;
	logic [31:0]   next_rdata;
	logic [1:0]    rresp;
	logic [1:0]    next_rresp;
	logic [NREG-1:0] rd_hit;

	assign s_axi_arready = ce && rd_state == FEQ_RD_IDLE;
	assign s_axi_rvalid  = rd_state == FEQ_RD_RESP;
	assign s_axi_rdata   = rdata;
	assign s_axi_rresp   = rresp;

	// decode read address straight off the bus; arready gates the capture
	always_comb begin
		rd_hit = '0;
		for (int i = 0; i < NREG; i++) begin
			if (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[13:2] == IDX[i]) rd_hit[i] = 1'b1;
		end
	end

	assign rif.rd_sel = rd_hit;

	// mux of the selected register; bits above 15 read as zero
	always_comb begin
		rif.rd_data = 16'h0000;
		for (int i = 0; i < NREG; i++) begin
			if (rif.rd_sel[i]) rif.rd_data = rif.rd_data | regs[i];
		end
	end

	always_comb begin
		next_rd_state = rd_state;
		next_rdata    = rdata;
		next_rresp    = rresp;
		case (rd_state)
			FEQ_RD_IDLE: begin
				if (s_axi_arvalid && s_axi_arready) begin
					next_rd_state = FEQ_RD_RESP;
					next_rdata    = {16'h0000, rif.rd_data};
					next_rresp    = (|rd_hit) ? `FEQ_RESP_OKAY : `FEQ_RESP_SLVERR;
				end
			end
			FEQ_RD_RESP: begin
				if (ce && s_axi_rready) next_rd_state = FEQ_RD_IDLE;
			end
			default: next_rd_state = FEQ_RD_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_state <= FEQ_RD_IDLE;
			rdata    <= 32'h00000000;
			rresp    <= `FEQ_RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			rdata    <= next_rdata;
			rresp    <= next_rresp;
		end
	end

	// ---- tap weight outputs, registered ----
	// the A taps serve both modes unchanged; B taps are zeroed outside dual mode
	// so a single-channel filter gets zero B weights from the first ce-high clock after the switch
	logic signed [11:0] next_a6, next_a7, next_a8, next_a9, next_b1, next_b2, next_b3;

	always_comb begin
		next_a6 = regs[0][11:0];
		next_a7 = regs[1][11:0];
		next_a8 = regs[2][11:0];
		next_a9 = regs[3][11:0];
		next_b1 = dual_mode ? regs[4][11:0] : 12'h000;
		next_b2 = dual_mode ? regs[5][11:0] : 12'h000;
		next_b3 = dual_mode ? regs[6][11:0] : 12'h000;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_a_tap6_weight <= 12'h000;
			chan_a_tap7_weight <= 12'h000;
			chan_a_tap8_weight <= 12'h000;
			chan_a_tap9_weight <= 12'h000;
			chan_b_tap1_weight <= 12'h000;
			chan_b_tap2_weight <= 12'h000;
			chan_b_tap3_weight <= 12'h000;
		end else if (ce) begin
			chan_a_tap6_weight <= next_a6;
			chan_a_tap7_weight <= next_a7;
			chan_a_tap8_weight <= next_a8;
			chan_a_tap9_weight <= next_a9;
			chan_b_tap1_weight <= next_b1;
			chan_b_tap2_weight <= next_b2;
			chan_b_tap3_weight <= next_b3;
		end
	end

	// ---- assertions ----
	property p_a6_follows;
		@(posedge clk) disable iff (!rst_n)
		ce |=> chan_a_tap6_weight == $past(regs[0][11:0]);
	endproperty
	a_a6_follows: assert property (p_a6_follows) else $error("tap6 weight mismatch");

	property p_a7_follows;
		@(posedge clk) disable iff (!rst_n)
		ce |=> chan_a_tap7_weight == $past(regs[1][11:0]);
	endproperty
	a_a7_follows: assert property (p_a7_follows) else $error("tap7 weight mismatch");

	property p_a8_follows;
		@(posedge clk) disable iff (!rst_n)
		ce |=> chan_a_tap8_weight == $past(regs[2][11:0]);
	endproperty
	a_a8_follows: assert property (p_a8_follows) else $error("tap8 weight mismatch");

	property p_a9_write;
		@(posedge clk) disable iff (!rst_n)
		(wr_fire && wr_hit[3] && w_strb[1:0] == 2'h3) ##1 ce |=>
			chan_a_tap9_weight == $past(w_data[11:0], 2);
	endproperty
	a_a9_write: assert property (p_a9_write) else $error("tap9 write not applied");

	property p_b1_mode;
		@(posedge clk) disable iff (!rst_n)
		(ce && !dual_mode) |=> chan_b_tap1_weight == 12'h000;
	endproperty
	a_b1_mode: assert property (p_b1_mode) else $error("B tap1 live in single mode");

	property p_b2_follows;
		@(posedge clk) disable iff (!rst_n)
		(ce && dual_mode) |=> chan_b_tap2_weight == $past(regs[5][11:0]);
	endproperty
	a_b2_follows: assert property (p_b2_follows) else $error("B tap2 mismatch");

	property p_b3_follows;
		@(posedge clk) disable iff (!rst_n)
		(ce && dual_mode) |=> chan_b_tap3_weight == $past(regs[6][11:0]);
	endproperty
	a_b3_follows: assert property (p_b3_follows) else $error("B tap3 mismatch");

	property p_rd_upper_zero;
		@(posedge clk) disable iff (!rst_n)
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("upper read bits set");

	property p_bvalid_holds;
		@(posedge clk) disable iff (!rst_n)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bvalid_holds: assert property (p_bvalid_holds) else $error("bvalid dropped early");

	property p_wt_reset_zero;
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> !(|{chan_a_tap6_weight, chan_a_tap9_weight, chan_b_tap1_weight});
	endproperty
	a_wt_reset_zero: assert property (p_wt_reset_zero) else $error("weight set after reset");

endmodule : feq_coef_bank

/* verif/tb_top.sv */
// tb_top.sv: self-checking bench for the equalizer coefficient bank over axi4-lite
// assumes: feq_cfg.svh on the include path; design files compiled before this one
`timescale 1ns/1ps
`include "feq_cfg.svh"
module tb_top
	import feq_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic        ce;
	logic        dual_mode;
	logic [13:0] s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [13:0] s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [11:0] wt [7];
	int          error_cnt;
	int          n_compared;

	feq_coef_bank feq_coef_bank_i (
		.clk(clk), .rst_n(rst_n), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .dual_mode(dual_mode),
		.chan_a_tap6_weight(wt[0]), .chan_a_tap7_weight(wt[1]), .chan_a_tap8_weight(wt[2]),
		.chan_a_tap9_weight(wt[3]), .chan_b_tap1_weight(wt[4]), .chan_b_tap2_weight(wt[5]),
		.chan_b_tap3_weight(wt[6])
	);

	// 200 mhz
	always #2.5 clk = ~clk;

	// byte address of register i: index times four
	function automatic logic [13:0] adr(input int i);
		logic [11:0] x [7] = '{`FEQ_IDX_A_TAP6, `FEQ_IDX_A_TAP7, `FEQ_IDX_A_TAP8,
			`FEQ_IDX_A_TAP9, `FEQ_IDX_B_TAP1, `FEQ_IDX_B_TAP2, `FEQ_IDX_B_TAP3};
		return {x[i], 2'b00};
	endfunction : adr

	// distinct pattern per register, reserved bits nonzero and tap negative
	function automatic logic [15:0] val(input int i);
		return {4'hF - 4'(i), 12'h801 + 12'(i * 37)};
	endfunction : val

	task automatic report_and_stop();
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic miss(input string m);
		error_cnt++;
		$display("MISMATCH %0t %s", $time, m);
	endtask : miss

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp)
			miss($sformatf("%s got %h exp %h", m, got, exp));
	endtask : chk

	// ready is sampled at the falling edge, where it is settled for the next rising edge
	task automatic axi_wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic late, output logic [1:0] r);
		int   n;
		logic ta, tw, da, dw;
		n = 0;
		da = 1'b0;
		dw = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !late;
		do begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			da = da | ta;
			dw = dw | tw;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
		end while (!(da && dw) && n < 50);
		do begin
			@(negedge clk);
			n++;
		end while (!s_axi_bvalid && n < 100);
		if (n >= 100) miss("write not answered");
		// late mode: bready held off, so the response must stand on its own
		if (late) begin
			repeat (3) @(posedge clk);
			s_axi_bready <= 1'b1;
			@(negedge clk);
			chk({31'h0, s_axi_bvalid}, 32'h1, "bvalid held until bready");
		end
		r = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic ta;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk);
			ta = s_axi_arready;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			n++;
		end while (!ta && n < 50);
		do begin
			@(negedge clk);
			n++;
		end while (!s_axi_rvalid && n < 100);
		if (n >= 100) miss("read not answered");
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// read one register and compare data and response
	task automatic rd_chk(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		chk(d, e, "read data");
		chk({30'h0, r}, {30'h0, er}, "read resp");
	endtask : rd_chk

	// every register and weight reads zero after a reset
	task automatic t_reset_vals();
		for (int i = 0; i < 7; i++) begin
			rd_chk(adr(i), 32'h0, `FEQ_RESP_OKAY);
			chk({20'h0, wt[i]}, 32'h0, "weight after reset");
		end
	endtask : t_reset_vals

	// each register reaches its own tap; b taps only in dual mode
	task automatic chk_wts(input logic d);
		logic [15:0] e;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 7; i++) begin
			e = val(i);
			chk({20'h0, wt[i]}, (i > 3 && !d) ? 32'h0 : {20'h0, e[11:0]}, "weight");
		end
	endtask : chk_wts

	// write all first, then read all, so an aliased decode shows up
	task automatic t_map();
		logic [1:0] r;
		for (int i = 0; i < 7; i++) begin
			axi_wr(adr(i), {16'hDEAD, val(i)}, 4'hF, 1'b0, r);
			chk({30'h0, r}, {30'h0, `FEQ_RESP_OKAY}, "write resp");
		end
		for (int i = 0; i < 7; i++)
			rd_chk(adr(i), {16'h0, val(i)}, `FEQ_RESP_OKAY);
		chk_wts(1'b1);
		@(posedge clk);
		dual_mode <= 1'b0;
		chk_wts(1'b0);
		@(posedge clk);
		dual_mode <= 1'b1;
		chk_wts(1'b1);
	endtask : t_map

	// byte lanes write only their own half of tap and reserved field
	task automatic t_lanes();
		logic [1:0]  r;
		logic [15:0] v;
		v = val(3);
		axi_wr(adr(3), 32'hFFFF_FFFF, 4'h1, 1'b0, r);
		rd_chk(adr(3), {16'h0, v[15:8], 8'hFF}, `FEQ_RESP_OKAY);
		axi_wr(adr(3), 32'h0000_0000, 4'h2, 1'b0, r);
		axi_wr(adr(3), 32'h0000_0000, 4'hC, 1'b0, r);
		rd_chk(adr(3), 32'h0000_00FF, `FEQ_RESP_OKAY);
		repeat (2) @(negedge clk);
		chk({20'h0, wt[3]}, 32'h0000_00FF, "lane weight");
	endtask : t_lanes

	// gaps and misaligned addresses are refused and leave neighbours alone
	task automatic t_unmapped();
		logic [1:0]  r;
		logic [13:0] bad [2];
		bad = '{adr(1) + 14'h4, adr(1) + 14'h2};
		for (int k = 0; k < 2; k++) begin
			axi_wr(bad[k], 32'h0000_0FFF, 4'hF, 1'b1, r);
			chk({30'h0, r}, {30'h0, `FEQ_RESP_SLVERR}, "unmapped write resp");
			rd_chk(bad[k], 32'h0, `FEQ_RESP_SLVERR);
		end
		rd_chk(adr(1), {16'h0, val(1)}, `FEQ_RESP_OKAY);
		rd_chk(adr(2), {16'h0, val(2)}, `FEQ_RESP_OKAY);
	endtask : t_unmapped

	// clock enable low holds every ready low
	// a mode change while frozen must not reach the weights
	task automatic t_ce();
		logic [15:0] v;
		v = val(4);
		@(posedge clk);
		ce <= 1'b0;
		dual_mode <= 1'b0;
		repeat (2) @(negedge clk);
		chk({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0, "ready with ce low");
		chk({20'h0, wt[4]}, {20'h0, v[11:0]}, "weight frozen with ce low");
		@(posedge clk);
		ce <= 1'b1;
		dual_mode <= 1'b1;
	endtask : t_ce

	// second reset in mid-run clears written values again
	task automatic t_rereset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_vals();
	endtask : t_rereset

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		dual_mode = 1'b1;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		error_cnt = 0;
		n_compared = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_vals();
		t_map();
		t_lanes();
		t_unmapped();
		t_ce();
		t_rereset();
		report_and_stop();
	end

	// the sequence needs well under 2000 cycles; a hang stops here
	initial begin
		repeat (20000) @(posedge clk);
		miss("watchdog expired");
		report_and_stop();
	end
endmodule : tb_top
